// >>> rtl/ccp_pwm.sv
`timescale 1ns/10ps
`include "ccp_pwm_consts.svh"

// Functional notes
// - period is (period_register+1) x 4 clocks x prescale value
// - after count equals period: count cleared, pin set unless duty zero, shadow loaded
// - postscaler setting never affects pwm period or frequency
// - duty is duty_high_bits as msbs plus control bits 5:4 as lsbs
// - duty may be written anytime; takes effect only at period boundary
// - duty_shadow is read-only while pwm mode is active
// - shadow plus hidden 2-bit latch double buffer the duty value
// - time base is count plus phase bits or two prescaler bits
// - pin driven low when time base equals buffered duty value
// - high time equals duty value x clock period x prescale
// - duty beyond period leaves pin unchanged, no clear inside period
// - resolution is log2 of 4 x (period+1), ten bits at 255
// - in sleep count stops, state holds, pin keeps level, resumes later
// - reset returns registers to reset values and pin to input
// - writing zero to module control releases the output pin
// - prescaler offers division by 1, 4 and 16
// - all pwm timing derives from the system clock
module ccp_pwm
    import ccp_pwm_pkg::*;
#(
    parameter logic [3:0] PWM_MODE_CODE = `PWM_MODE_CODE_DEF
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic sleep_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic pwm_output_pin_o,
    output logic pwm_output_pin_oe_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // last prescaler count: one timer step is 4 x ratio clocks
    function automatic logic [5:0] pre_last(input logic [1:0] psc);
        case (psc)
            `PRESCALE_1: pre_last = `PRE_LAST_1;
            `PRESCALE_4: pre_last = `PRE_LAST_4;
            default: pre_last = `PRE_LAST_16;
        endcase
    endfunction

    // two low time-base bits: clock phase at 1:1, prescaler bits otherwise
    function automatic logic [1:0] tb_low(input logic [5:0] pre, input logic [1:0] psc);
        case (psc)
            `PRESCALE_1: tb_low = pre[1:0];
            `PRESCALE_4: tb_low = pre[3:2];
            default: tb_low = pre[5:4];
        endcase
    endfunction

    // word address check: only aligned offsets inside the map hit
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[1:0] == 2'h0) && (a <= `OFS_PIN_CONTROL);
    endfunction

    // ------------------------------------------------------------------
    // state and decoded terms
    // ------------------------------------------------------------------
    pwm_state_t state_reg;
    pwm_state_t state_next;
    logic pwm_active;
    logic timer_run;
    logic step;
    logic boundary;
    logic match;
    logic [9:0] time_base;
    logic [9:0] duty_buf;
    logic [9:0] duty_new;
    logic do_wr;
    logic wr_tmr;
    logic ar_take;

    // postscaler bits tctl[6:3] are stored only, never read here
    assign pwm_active = (state_reg.ctl[`CTL_MODE_MSB:0] & `PWM_MODE_MASK)
                        == (PWM_MODE_CODE & `PWM_MODE_MASK);
    assign timer_run = state_reg.tctl[`TCTL_RUN];
    // system clock alone paces the time base, frozen in sleep
    assign step = timer_run && !sleep_i
                  && (state_reg.pre == pre_last(state_reg.tctl[1:0]));
    assign boundary = step && (state_reg.tmr == state_reg.period);
    assign time_base = {state_reg.tmr, tb_low(state_reg.pre, state_reg.tctl[1:0])};
    assign duty_buf = {state_reg.shadow, state_reg.lat2};
    // new duty: high bits plus the two control bits
    assign duty_new = {state_reg.duty_hi,
                       state_reg.ctl[`CTL_DUTY_BIT1], state_reg.ctl[`CTL_DUTY_BIT0]};
    assign do_wr = state_reg.aw_ok && state_reg.w_ok && !state_reg.bvalid;
    assign wr_tmr = do_wr && state_reg.w_lane0 && (state_reg.aw_addr == `OFS_TIMER_COUNT);
    assign ar_take = s_axi_arvalid_i && !state_reg.rvalid;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------

    // bus slave first, then the timer, so hardware events win over clears
    always_comb begin
        logic [7:0] wd;
        logic [31:0] rd;
        logic [9:0] tb_nx;
        tb_nx = 10'h000;
        wd = state_reg.w_data;
        rd = 32'h0000_0000;
        state_next = state_reg;

        // write address and data are taken independently
        if (s_axi_awvalid_i && !state_reg.aw_ok) begin
            state_next.aw_ok = 1'b1;
            state_next.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !state_reg.w_ok) begin
            state_next.w_ok = 1'b1;
            state_next.w_data = s_axi_wdata_i[7:0];
            state_next.w_lane0 = s_axi_wstrb_i[0];
        end
        if (state_reg.bvalid && s_axi_bready_i) begin
            state_next.bvalid = 1'b0;
        end

        // register write: only byte lane 0 carries data, upper lanes ignored
        if (do_wr) begin
            state_next.aw_ok = 1'b0;
            state_next.w_ok = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = addr_hit(state_reg.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            if (state_reg.w_lane0) begin
                case (state_reg.aw_addr)
                    `OFS_MODULE_CONTROL: state_next.ctl = wd & `CTL_WMASK;
                    `OFS_DUTY_LOW: state_next.duty_hi = wd;
                    `OFS_DUTY_SHADOW: begin
                        // shadow is owned by the timer while pwm runs
                        if (!pwm_active) begin
                            state_next.shadow = wd;
                        end
                    end
                    `OFS_TIMER_PERIOD: state_next.period = wd;
                    `OFS_TIMER_CONTROL: state_next.tctl = wd & `TCTL_WMASK;
                    `OFS_TIMER_COUNT: begin
                        state_next.tmr = wd;
                        state_next.pre = 6'h00;
                    end
                    `OFS_TIMER_STATUS: begin
                        if (wd[`STAT_FLAG]) begin
                            state_next.flag = 1'b0;
                        end
                    end
                    `OFS_PIN_CONTROL: begin
                        state_next.pin_dir = wd[`PIN_DIR];
                        state_next.port_q = wd[`PIN_DATA];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // register read
        case (s_axi_araddr_i)
            `OFS_MODULE_CONTROL: rd = {24'h000000, state_reg.ctl};
            `OFS_DUTY_LOW: rd = {24'h000000, state_reg.duty_hi};
            `OFS_DUTY_SHADOW: rd = {24'h000000, state_reg.shadow};
            `OFS_TIMER_PERIOD: rd = {24'h000000, state_reg.period};
            `OFS_TIMER_CONTROL: rd = {24'h000000, state_reg.tctl};
            `OFS_TIMER_COUNT: rd = {24'h000000, state_reg.tmr};
            `OFS_TIMER_STATUS: rd = {31'h0000_0000, state_reg.flag};
            `OFS_PIN_CONTROL: rd = {30'h0000_0000, state_reg.port_q, state_reg.pin_dir};
            default: rd = 32'h0000_0000;
        endcase
        if (ar_take) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = rd;
            state_next.rresp = addr_hit(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (state_reg.rvalid && s_axi_rready_i) begin
            state_next.rvalid = 1'b0;
        end

        // prescaler and timer; a software count load wins over a step
        if (timer_run && !sleep_i && !wr_tmr) begin
            state_next.pre = step ? 6'h00 : state_reg.pre + 6'h01;
            if (boundary) begin
                state_next.tmr = 8'h00;
                state_next.flag = 1'b1;
            end else if (step) begin
                state_next.tmr = state_reg.tmr + 8'h01;
            end
        end

        // compare the time base this edge enters, so the pin falls after exactly duty steps;
        // a duty above the period never matches, so no clear inside the period
        tb_nx = {state_next.tmr, tb_low(state_next.pre, state_reg.tctl[1:0])};
        match = (tb_nx == duty_buf);

        // output latch: cleared on duty match, set at the boundary
        if (!pwm_active) begin
            state_next.pwm_q = 1'b0;
        end else if (!sleep_i) begin
            if (match) begin
                state_next.pwm_q = 1'b0;
            end
            if (boundary) begin
                // the new duty is buffered only here, never mid-period
                state_next.shadow = state_reg.duty_hi;
                state_next.lat2 = duty_new[1:0];
                state_next.pwm_q = (duty_new != 10'h000);
            end
        end

        // pin returns to the port latch when the mode is left
        state_next.pin_q = pwm_active ? state_next.pwm_q : state_next.port_q;
        if ((state_next.ctl[`CTL_MODE_MSB:0] & `PWM_MODE_MASK)
            != (PWM_MODE_CODE & `PWM_MODE_MASK)) begin
            state_next.pin_q = state_next.port_q;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------

    // every field has a constant reset; pin starts as input
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= '0;
            state_reg.pin_dir <= `RST_PIN_DIR;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready_o = !state_reg.aw_ok;
    assign s_axi_wready_o = !state_reg.w_ok;
    assign s_axi_bvalid_o = state_reg.bvalid;
    assign s_axi_bresp_o = state_reg.bresp;
    assign s_axi_arready_o = !state_reg.rvalid;
    assign s_axi_rvalid_o = state_reg.rvalid;
    assign s_axi_rdata_o = state_reg.rdata;
    assign s_axi_rresp_o = state_reg.rresp;
    assign pwm_output_pin_o = state_reg.pin_q;
    assign pwm_output_pin_oe_o = !state_reg.pin_dir;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_boundary;
        boundary && !wr_tmr;
    endsequence

    sequence s_fast_step;
        step && (state_reg.tctl[1:0] == `PRESCALE_1);
    endsequence

    sequence s_quiet3;
        (!step && timer_run && !sleep_i && !wr_tmr
         && (state_reg.tctl[1:0] == `PRESCALE_1))[*3];
    endsequence

    property p_wrap;
        s_boundary |=> (state_reg.tmr == 8'h00) && state_reg.flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count not cleared at period end");

    property p_flag;
        s_boundary |=> state_reg.flag;
    endproperty
    a_flag: assert property (p_flag) else $error("period flag not raised");

    property p_shadow_load;
        (s_boundary and pwm_active)
            |=> ({state_reg.shadow, state_reg.lat2} == $past(duty_new));
    endproperty
    a_shadow_load: assert property (p_shadow_load) else $error("duty not buffered");

    property p_shadow_hold;
        (pwm_active && !boundary) |=> $stable(state_reg.shadow) && $stable(state_reg.lat2);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("shadow moved mid-period");

    property p_clear;
        (pwm_active && !sleep_i && match && !boundary && $stable(state_reg.ctl))
            |=> !state_reg.pwm_q;
    endproperty
    a_clear: assert property (p_clear) else $error("pin not cleared at duty match");

    property p_zero_duty;
        (s_boundary and (pwm_active && duty_new == 10'h000)) |=> !state_reg.pwm_q;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("pin set with zero duty");

    property p_sleep;
        (sleep_i && !wr_tmr && $stable(state_reg.ctl))
            |=> $stable(state_reg.tmr) && $stable(state_reg.pwm_q);
    endproperty
    a_sleep: assert property (p_sleep) else $error("state moved in sleep");

    property p_fast_period;
        s_fast_step ##1 s_quiet3 |=> (state_reg.pre == `PRE_LAST_1);
    endproperty
    a_fast_period: assert property (p_fast_period) else $error("1:1 step not 4 clocks");

    property p_over_period;
        (pwm_active && !sleep_i && !boundary && state_reg.pwm_q && $stable(state_reg.ctl)
         && duty_buf > {state_reg.period, 2'h3}) |=> state_reg.pwm_q;
    endproperty
    a_over_period: assert property (p_over_period) else $error("pin cleared beyond period");

    property p_release;
        (state_reg.ctl == 8'h00) |-> (pwm_output_pin_o == state_reg.port_q);
    endproperty
    a_release: assert property (p_release) else $error("pin not released");

    // a non-zero duty starts every period with the pin high
    property p_set_boundary;
        (s_boundary and (pwm_active && duty_new != 10'h000)) |=> state_reg.pwm_q;
    endproperty
    a_set_boundary: assert property (p_set_boundary)
        else $error("pin not set at period start");

    // the period flag only ever rises on a period match; software can only clear it
    property p_flag_source;
        (!state_reg.flag && !(boundary && !wr_tmr)) |=> !state_reg.flag;
    endproperty
    a_flag_source: assert property (p_flag_source)
        else $error("period flag set without a match");

    // a stopped or sleeping timer keeps its count and its phase
    property p_frozen;
        ((sleep_i || !timer_run) && !wr_tmr)
            |=> $stable(state_reg.tmr) && $stable(state_reg.pre);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("timer moved while frozen");

    // outside pwm mode the pin shows the port data latch
    property p_port_pin;
        !pwm_active |=> (pwm_output_pin_o == state_reg.port_q);
    endproperty
    a_port_pin: assert property (p_port_pin)
        else $error("pin not taken from port latch");

    // the time base moves at most one step per edge, so the pin holds until it nears the duty
    property p_hold_high;
        (pwm_active && !boundary && !wr_tmr && state_reg.pwm_q
         && (({1'b0, time_base} + 11'h001) < {1'b0, duty_buf})) |=> state_reg.pwm_q;
    endproperty
    a_hold_high: assert property (p_hold_high)
        else $error("pin cleared before duty reached");

endmodule // ccp_pwm

// >>> rtl/ccp_pwm_consts.svh
`ifndef CCP_PWM_CONSTS_SVH
`define CCP_PWM_CONSTS_SVH

// ------------------------------------------------------------------
// register byte offsets (one 32-bit word each)
// ------------------------------------------------------------------
`define OFS_MODULE_CONTROL 8'h00
`define OFS_DUTY_LOW 8'h04
`define OFS_DUTY_SHADOW 8'h08
`define OFS_TIMER_PERIOD 8'h0C
`define OFS_TIMER_CONTROL 8'h10
`define OFS_TIMER_COUNT 8'h14
`define OFS_TIMER_STATUS 8'h18
`define OFS_PIN_CONTROL 8'h1C

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define CTL_DUTY_BIT1 5
`define CTL_DUTY_BIT0 4
`define CTL_MODE_MSB 3
`define CTL_WMASK 8'h3F
`define TCTL_RUN 2
`define TCTL_WMASK 8'h7F
`define STAT_FLAG 0
`define PIN_DIR 0
`define PIN_DATA 1

// ------------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_PIN_DIR 1'b1
`define PWM_MODE_CODE_DEF 4'hC
`define PWM_MODE_MASK 4'hC
`define PRESCALE_1 2'h0
`define PRESCALE_4 2'h1
`define PRE_LAST_1 6'h03
`define PRE_LAST_4 6'h0F
`define PRE_LAST_16 6'h3F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> rtl/ccp_pwm_pkg.sv
package ccp_pwm_pkg;

    // whole state of the pwm block, registered in one process
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] duty_hi;
        logic [7:0] shadow;
        logic [7:0] period;
        logic [7:0] tctl;
        logic [7:0] tmr;
        logic [5:0] pre;
        logic [1:0] lat2;
        logic pwm_q;
        logic pin_q;
        logic flag;
        logic pin_dir;
        logic port_q;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic w_ok;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pwm_state_t;

endpackage

// >>> bench/pwm_load_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// load on the pwm pin: resolves the line and times its waveform
// ----------------------------------------------------------------
module pwm_load_model (
    input wire logic mclk_i,
    input wire logic pin_i,
    input wire logic oe_i,
    output logic level_o,
    output logic [15:0] high_o,
    output logic [15:0] per_o
);
    logic [15:0] hcnt = 16'h0000;
    logic [15:0] pcnt = 16'h0000;
    logic prev = 1'h0;

    // an undriven line falls to the pull-down, never keeps the last level
    assign level_o = oe_i ? pin_i : 1'h0;

    // period and high time, rising edge to rising edge
    always @(posedge mclk_i) begin
        prev <= level_o;
        if (level_o && !prev) begin
            per_o <= pcnt;
            high_o <= hcnt;
            pcnt <= 16'h0001;
            hcnt <= 16'h0001;
        end else begin
            pcnt <= pcnt + 16'h0001;
            hcnt <= hcnt + {15'h0000, level_o};
        end
    end
endmodule // pwm_load_model

// >>> bench/tb.sv
`timescale 1ns/10ps
module tb;
    logic mclk = 1'h0;
    logic arst_n = 1'h0;
    logic sleep = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, pin, oe, level;
    logic [1:0] bresp, rresp, wresp;
    logic [31:0] rdata;
    logic [15:0] high, per;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    // ----------------------------------------------------------------
    // clock, design and pin load
    // ----------------------------------------------------------------
    always #12.5 mclk = ~mclk;

    ccp_pwm DUT (.mclk_i(mclk), .arst_n_i(arst_n), .sleep_i(sleep),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
        .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .pwm_output_pin_o(pin), .pwm_output_pin_oe_o(oe));

    pwm_load_model load (.mclk_i(mclk), .pin_i(pin), .oe_i(oe), .level_o(level),
        .high_o(high), .per_o(per));

    // ----------------------------------------------------------------
    // report and bus tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // bready is offered with the request so no response edge is missed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= {24'h000000, d};
        bready <= 1'h1;
        forever begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                wresp = bresp;
                bready <= 1'h0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        forever begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'h0;
                break;
            end
        end
    endtask

    task automatic count_high(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(posedge mclk);
            if (level === 1'h1) h++;
        end
    endtask

    // bring-up order runs a whole first period, buffering the duty, before the driver is on
    task automatic setup(input logic [7:0] pr, input logic [9:0] duty, input logic [1:0] ps);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        wr(8'h1C, 8'h01);
        wr(8'h10, 8'h00);
        wr(8'h0C, pr);
        wr(8'h14, 8'h00);
        wr(8'h00, {2'h0, duty[1:0], 4'hC});
        wr(8'h04, duty[9:2]);
        wr(8'h18, 8'h01);
        wr(8'h10, {1'h0, 4'hF, 1'h1, ps});
        d = 32'h0;
        n = 0;
        while (d[0] !== 1'h1 && n < 2000) begin
            rd(8'h18, d, r);
            n++;
        end
        chk("period flag", 32'h1, d);
        wr(8'h1C, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        chk("oe at reset", 32'h0, {31'h0, oe});
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), d, r);
            chk("reset value", (i == 7) ? 32'h1 : 32'h0, d);
        end
        rd(8'h20, d, r);
        chk("unmapped resp", 32'h2, {30'h0, r});
        wr(8'h20, 8'h55);
        chk("unmapped write resp", 32'h2, {30'h0, wresp});
    endtask

    task automatic t_wave(input logic [7:0] pr, input logic [9:0] duty, input logic [1:0] ps,
        input int n);
        int p;
        p = (pr + 1) * 4 * n;
        setup(pr, duty, ps);
        repeat (3 * p) @(posedge mclk);
        chk("period", 32'(p), 32'(per));
        chk("high time", 32'(duty * n), 32'(high));
    endtask

    task automatic t_flat(input logic [9:0] duty, input int exp);
        int h;
        setup(8'h00, duty, 2'h0);
        repeat (8) @(posedge mclk);
        count_high(40, h);
        chk("high cycles", 32'(exp), 32'(h));
    endtask

    // duty written while frozen must wait for a period boundary
    task automatic t_sleep;
        logic [31:0] a;
        logic [31:0] b;
        logic [1:0] r;
        int h;
        setup(8'h01, 10'h005, 2'h0);
        sleep <= 1'h1;
        rd(8'h14, a, r);
        wr(8'h04, 8'h02);
        count_high(40, h);
        rd(8'h14, b, r);
        chk("count in sleep", a, b);
        chk("pin in sleep", (h == 0) ? 32'h0 : 32'h28, 32'(h));
        rd(8'h08, b, r);
        chk("shadow held", 32'h1, b);
        wr(8'h08, 8'hAA);
        rd(8'h08, b, r);
        chk("shadow read-only", 32'h1, b);
        sleep <= 1'h0;
        repeat (16) @(posedge mclk);
        rd(8'h08, b, r);
        chk("shadow loaded", 32'h2, b);
    endtask

    task automatic t_release;
        int h;
        wr(8'h00, 8'h00);
        chk("write resp", 32'h0, {30'h0, wresp});
        repeat (2) @(posedge mclk);
        count_high(20, h);
        chk("released pin", 32'h0, 32'(h));
        wr(8'h1C, 8'h02);
        repeat (2) @(posedge mclk);
        count_high(20, h);
        chk("port latch", 32'h14, 32'(h));
    endtask

    task automatic t_rereset;
        logic [31:0] d;
        logic [1:0] r;
        arst_n <= 1'h0;
        @(posedge mclk);
        arst_n <= 1'h1;
        chk("oe after reset", 32'h0, {31'h0, oe});
        rd(8'h1C, d, r);
        chk("pin control", 32'h1, d);
        rd(8'h00, d, r);
        chk("module control", 32'h0, d);
    endtask

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'h1;
        t_reset;
        t_wave(8'h00, 10'h002, 2'h0, 1);
        t_wave(8'h01, 10'h005, 2'h1, 4);
        t_wave(8'h01, 10'h007, 2'h2, 16);
        t_wave(8'h01, 10'h003, 2'h3, 16);
        t_wave(8'hFF, 10'h3FF, 2'h0, 1);
        t_flat(10'h000, 0);
        t_flat(10'h008, 40);
        t_sleep;
        t_release;
        t_rereset;
        test_done;
    end

    // whole run needs well under this many cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            test_done;
        end
    end
endmodule // tb
